// *** hspwm_pkg.sv ***
// ============================================================
// shared constants of the high speed pwm core
// ============================================================
package hspwm_pkg;

   // ============================================================
   // structure
   // ============================================================
   localparam int NGEN = 3;                   // pwm generators
   localparam int CW   = 16;                  // time base counter width
   localparam int NPIN = 2 * NGEN;            // high and low side output pins in total
   localparam int NSYN = 2 * NGEN + 2;        // synchronised pin inputs

   // ============================================================
   // synchroniser lane positions
   // ============================================================
   localparam int LANE_FLT  = 0;              // fault lanes 0..2
   localparam int LANE_CL   = NGEN;           // current limit lanes 3..5
   localparam int LANE_SAFE = 2 * NGEN;       // safety fault lane
   localparam int LANE_EXT  = 2 * NGEN + 1;   // external sync lane

   // ============================================================
   // timing
   // ============================================================
   localparam int RES_PS    = 8320;           // step at full core rate
   localparam int CORE_MIPS = 60;             // rate for that step
   localparam int CLK_NS    = 50;             // clk_sys period here
   localparam int PRE_W     = 8;              // prescaler counter width
   localparam int CHOP_W    = 8;              // chop divider width

   // ============================================================
   // reset values
   // ============================================================
   localparam logic          SAFE_LATCH_RST = 1'h1;    // latched at reset
   localparam logic [CW-1:0] CNT_RST        = 16'h0000;
   localparam logic [PRE_W-1:0]  PRE_RST    = 8'h00;
   localparam logic [CHOP_W-1:0] CHOP_RST   = 8'h00;
   localparam logic [NSYN-1:0]   SYN_RST    = 8'h00;
   localparam logic [NGEN-1:0]   OUT_RST    = 3'h0;

endpackage : hspwm_pkg

// *** pwm_gen_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// settings into one generator and its raw waveforms back
// ============================================================
interface pwm_gen_if;
   logic [15:0] period;     // generator period
   logic [15:0] duty;       // active while counter below this
   logic [15:0] phase;      // counter load on master sync
   logic [15:0] trig_cmp;   // adc trigger point
   logic        center;     // center aligned counting
   logic        swap;       // exchange high and low pins
   logic        chop_en;    // gate outputs by chop clock
   logic        act_h;      // raw high side waveform
   logic        act_l;      // raw low side waveform
   logic        trig;       // adc trigger pulse

   modport core (output period, duty, phase, trig_cmp,
                 output center, swap, chop_en,
                 input  act_h, act_l, trig);
   modport gen  (input  period, duty, phase, trig_cmp,
                 input  center, swap, chop_en,
                 output act_h, act_l, trig);
endinterface : pwm_gen_if
`default_nettype wire

// *** pwm_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// one pwm generator: counter, shadows, swap, chop, trigger
// ============================================================
module pwm_gen (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // shared timing from the core
   input  wire logic tick,
   input  wire logic sync,
   input  wire logic chop_clk,
   // settings and waveforms
   pwm_gen_if.gen    gi
);
   logic [15:0] cnt_reg;    // generator counter
   logic [15:0] cnt_next;
   logic        dir_reg;    // 1 while counting down
   logic        dir_next;
   logic [15:0] per_reg;    // shadow period
   logic [15:0] duty_reg;   // shadow duty
   logic        trig_reg;   // registered trigger

   // ============================================================
   // period end detection
   // ============================================================
   wire ea_end = gi.center ? 1'b0 : (cnt_reg >= per_reg);
   wire up_end = gi.center & ~dir_reg & (cnt_reg >= per_reg);
   wire dn_end = gi.center & dir_reg & (cnt_reg == 16'h0000);
   wire wrap   = ea_end | dn_end;
   // shadows load at own period end and on every master sync
   wire load   = sync | (tick & wrap);
   wire go_dn  = up_end | (dir_reg & ~dn_end);

   // counter restarts at edge aligned period end, turns in center mode, phase load on master sync
   assign cnt_next = sync    ? gi.phase :
                     !tick   ? cnt_reg :
                     ea_end  ? 16'h0000 :
                     go_dn   ? cnt_reg - 16'h0001 :
                               cnt_reg + 16'h0001;
   assign dir_next = sync ? 1'b0 : !tick ? dir_reg :
                     up_end ? 1'b1 : dn_end ? 1'b0 : dir_reg;

   // ============================================================
   // waveform: active below duty, complementary low side
   // ============================================================
   wire act    = cnt_reg < duty_reg;
   // chop gates both pins, so the pair is never on together
   wire gate   = gi.chop_en ? chop_clk : 1'b1;
   wire wav_h  = act & gate;
   wire wav_l  = ~act & gate;
   assign gi.act_h = gi.swap ? wav_l : wav_h;
   assign gi.act_l = gi.swap ? wav_h : wav_l;
   assign gi.trig  = trig_reg;

   // counter state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_reg <= 16'h0000;
         dir_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         dir_reg <= dir_next;
      end
   end

   // shadows and trigger; trigger only on the up count
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         per_reg  <= 16'h0000;
         duty_reg <= 16'h0000;
         trig_reg <= 1'b0;
      end else begin
         if (load) begin
            per_reg  <= gi.period;
            duty_reg <= gi.duty;
         end
         trig_reg <= tick & ~dir_reg & (cnt_reg == gi.trig_cmp);
      end
   end

   // ============================================================
   // checks
   // ============================================================
   AST_GEN_ALIGN: assert property (@(posedge clk_sys) disable iff (rst)
      sync |=> cnt_reg == $past(gi.phase))
      else $error("generator not aligned to master sync");
   AST_GEN_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
      tick && !sync && !gi.center && cnt_reg >= per_reg |=> cnt_reg == 16'h0000)
      else $error("counter did not restart at period end");
   AST_GEN_TRIG: assert property (@(posedge clk_sys) disable iff (rst)
      tick && !dir_reg && cnt_reg == gi.trig_cmp |=> gi.trig ##1 !gi.trig)
      else $error("adc trigger not a single pulse at point");
   AST_GEN_SWAP: assert property (@(posedge clk_sys) disable iff (rst)
      gi.swap && !gi.chop_en |-> gi.act_h == (cnt_reg >= duty_reg))
      else $error("swap did not exchange waveforms");
   AST_GEN_CHOP: assert property (@(posedge clk_sys) disable iff (rst)
      gi.chop_en && !chop_clk |-> !gi.act_h && !gi.act_l)
      else $error("chop did not gate outputs");
   COV_GEN_CENTER: cover property (@(posedge clk_sys) disable iff (rst)
      gi.center && dn_end && tick);
endmodule : pwm_gen
`default_nettype wire

// *** high_speed_pwm_core.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - three generators, each a high/low pin pair
// - master time base aligns all generators
// - enabled fault or limit forces safe outputs
// - per-generator adc trigger at programmed point
// - special event trigger from master time base
// - master time base follows external sync input
// - sync output pulses at master period end
// - one counter step per prescaled clock
// - each generator owns its period and duty
// - high and low pins may be exchanged
// - center aligned and chopped modes offered
// - selectable prescaler ahead of time base
// - safety fault latched at reset until cleared
module high_speed_pwm_core (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // time base settings
   input  wire logic [1:0]            pre_sel,
   input  wire logic [15:0]           master_period,
   input  wire logic [15:0]           sevt_cmp,
   input  wire logic                  ext_sync_en,
   // per generator settings
   input  wire logic [2:0][15:0]      gen_period,
   input  wire logic [2:0][15:0]      gen_duty,
   input  wire logic [2:0][15:0]      gen_phase,
   input  wire logic [2:0][15:0]      gen_trig_cmp,
   input  wire logic [2:0]            center_en,
   input  wire logic [2:0]            swap_en,
   input  wire logic [2:0]            chop_en,
   input  wire logic [7:0]            chop_div,
   // protection settings
   input  wire logic                  flt_mon_en,
   input  wire logic                  cl_mon_en,
   input  wire logic [1:0]            flt_dat,
   input  wire logic [1:0]            cl_dat,
   input  wire logic                  fault_clear,
   // pins in
   input  wire logic [2:0]            fault_in,
   input  wire logic [2:0]            climit_in,
   input  wire logic                  safety_fault_input,
   input  wire logic                  external_sync_input,
   // pins out
   output logic [2:0]                 high_side_output,
   output logic [2:0]                 low_side_output,
   output logic                       time_base_sync_output,
   // adc triggers
   output logic [2:0]                 adc_trigger,
   output logic                       special_event_trigger,
   // status
   output logic                       safety_latched
);

   // ============================================================
   // declarations
   // ============================================================
   // pin synchroniser stages
   logic [hspwm_pkg::NSYN-1:0]    syn1_reg;     // first stage
   logic [hspwm_pkg::NSYN-1:0]    syn2_reg;     // second stage
   logic                          ext_prev_reg; // edge history
   // prescaler
   logic [hspwm_pkg::PRE_W-1:0]   pre_cnt_reg;
   // master time base
   logic [15:0]                   mtb_cnt_reg;
   logic [15:0]                   mtb_cnt_next;
   logic                          sync_out_reg; // sync pin
   logic                          sevt_reg;     // special trigger
   // chop clock divider
   logic [hspwm_pkg::CHOP_W-1:0]  chop_cnt_reg;
   logic                          chop_clk_reg;
   // safety latch
   logic                          safe_lat_reg;
   logic                          safe_lat_next;
   // output pins
   logic [2:0]                    hi_reg;
   logic [2:0]                    lo_reg;
   logic [2:0]                    hi_next;
   logic [2:0]                    lo_next;
   logic [2:0]                    trg_reg;
   // generator results
   logic [2:0]                    raw_h;
   logic [2:0]                    raw_l;
   logic [2:0]                    raw_trig;

   // ============================================================
   // prescaler mask
   // ============================================================
   // the divide ratio is a power of two, so a mask compare is
   // cheaper than a loadable down counter
   function automatic logic [7:0] div_mask(input logic [1:0] sel);
      logic [7:0] m;
      m = 8'h00;
      case (sel)
         2'h0: m = 8'h00;    // divide by 1
         2'h1: m = 8'h01;    // divide by 2
         2'h2: m = 8'h03;    // divide by 4
         default: m = 8'h07; // divide by 8
      endcase
      return m;
   endfunction : div_mask

   // ============================================================
   // pin synchronisers
   // ============================================================
   // all lanes come from pins outside clk_sys
   wire [hspwm_pkg::NSYN-1:0] pins_in = {external_sync_input,
                                          safety_fault_input,
                                          climit_in,
                                          fault_in};

   // two flip-flops per lane, first stage read only by second
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         syn1_reg     <= hspwm_pkg::SYN_RST;
         syn2_reg     <= hspwm_pkg::SYN_RST;
         ext_prev_reg <= 1'b0;
      end else begin
         syn1_reg     <= pins_in;
         syn2_reg     <= syn1_reg;
         ext_prev_reg <= syn2_reg[hspwm_pkg::LANE_EXT];
      end
   end

   // clean lanes
   wire [2:0] flt_s  = syn2_reg[hspwm_pkg::LANE_FLT +: 3];
   wire [2:0] cl_s   = syn2_reg[hspwm_pkg::LANE_CL +: 3];
   wire       safe_s = syn2_reg[hspwm_pkg::LANE_SAFE];
   wire       ext_s  = syn2_reg[hspwm_pkg::LANE_EXT];
   // rising edge of the external sync
   wire       ext_rise = ext_s & ~ext_prev_reg;

   // ============================================================
   // prescaler
   // ============================================================
   // tick is one clk_sys cycle wide; at divide by 1 it is always
   // high, giving one counter step per clock
   wire [7:0] pre_mask = div_mask(pre_sel);
   wire       tick     = (pre_cnt_reg & pre_mask) == pre_mask;

   // free running; only masked bits matter
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pre_cnt_reg <= hspwm_pkg::PRE_RST;
      end else begin
         pre_cnt_reg <= pre_cnt_reg + 8'h01;
      end
   end

   // ============================================================
   // master time base
   // ============================================================
   // an external sync restarts the base at once, so the period end
   // and the edge may coincide without a double restart
   wire mtb_end  = tick & (mtb_cnt_reg >= master_period);
   wire ext_hit  = ext_sync_en & ext_rise;
   wire mtb_wrap = mtb_end | ext_hit;

   assign mtb_cnt_next = mtb_wrap ? hspwm_pkg::CNT_RST :
                         tick     ? mtb_cnt_reg + 16'h0001 :
                                    mtb_cnt_reg;

   // special trigger point taken on the master count
   wire sevt_hit = tick & (mtb_cnt_reg == sevt_cmp);

   // base counter, sync pin and special trigger
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mtb_cnt_reg  <= hspwm_pkg::CNT_RST;
         sync_out_reg <= 1'b0;
         sevt_reg     <= 1'b0;
      end else begin
         mtb_cnt_reg  <= mtb_cnt_next;
         sync_out_reg <= mtb_wrap;
         sevt_reg     <= sevt_hit;
      end
   end

   // ============================================================
   // chop clock
   // ============================================================
   // toggles every chop_div+1 clocks; not tied to the time base
   // so chop edges drift against the pwm edges
   wire chop_end = chop_cnt_reg >= chop_div;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         chop_cnt_reg <= hspwm_pkg::CHOP_RST;
         chop_clk_reg <= 1'b0;
      end else if (chop_end) begin
         chop_cnt_reg <= hspwm_pkg::CHOP_RST;
         chop_clk_reg <= ~chop_clk_reg;
      end else begin
         chop_cnt_reg <= chop_cnt_reg + 8'h01;
      end
   end

   // ============================================================
   // generators
   // ============================================================
   // each generator has its own interface and settings
   for (genvar g = 0; g < hspwm_pkg::NGEN; g++) begin : gen_pwm
      pwm_gen_if gif ();
      // settings into the generator
      assign gif.period   = gen_period[g];
      assign gif.duty     = gen_duty[g];
      assign gif.phase    = gen_phase[g];
      assign gif.trig_cmp = gen_trig_cmp[g];
      assign gif.center   = center_en[g];
      assign gif.swap     = swap_en[g];
      assign gif.chop_en  = chop_en[g];
      // waveforms back
      assign raw_h[g]     = gif.act_h;
      assign raw_l[g]     = gif.act_l;
      assign raw_trig[g]  = gif.trig;

      pwm_gen u_gen (
         .clk_sys  (clk_sys),
         .rst      (rst),
         .tick     (tick),
         .sync     (mtb_wrap),
         .chop_clk (chop_clk_reg),
         .gi       (gif.gen)
      );
   end

   // ============================================================
   // safety fault latch
   // ============================================================
   // set while the pin is high; clear needs both the request and
   // a low pin, so an active pin always wins over the clear
   assign safe_lat_next = safe_s |
                          (safe_lat_reg & ~fault_clear);

   // ============================================================
   // output override
   // ============================================================
   // fault outranks current limit; safety latch counts as fault
   wire [2:0] flt_act = {3{safe_lat_reg}} |
                        ({3{flt_mon_en}} & flt_s);
   wire [2:0] cl_act  = {3{cl_mon_en}} & cl_s;

   assign hi_next = (flt_act & {3{flt_dat[1]}}) |
                    (~flt_act & cl_act & {3{cl_dat[1]}}) |
                    (~flt_act & ~cl_act & raw_h);
   assign lo_next = (flt_act & {3{flt_dat[0]}}) |
                    (~flt_act & cl_act & {3{cl_dat[0]}}) |
                    (~flt_act & ~cl_act & raw_l);

   // latch reset value is set, so power-up is fail safe
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         safe_lat_reg <= hspwm_pkg::SAFE_LATCH_RST;
      end else begin
         safe_lat_reg <= safe_lat_next;
      end
   end

   // pins come from flip-flops to avoid glitches at the drivers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hi_reg  <= hspwm_pkg::OUT_RST;
         lo_reg  <= hspwm_pkg::OUT_RST;
         trg_reg <= hspwm_pkg::OUT_RST;
      end else begin
         hi_reg  <= hi_next;
         lo_reg  <= lo_next;
         trg_reg <= raw_trig;
      end
   end

   // ============================================================
   // outputs
   // ============================================================
   assign high_side_output      = hi_reg;
   assign low_side_output       = lo_reg;
   assign time_base_sync_output = sync_out_reg;
   assign adc_trigger           = trg_reg;
   assign special_event_trigger = sevt_reg;
   assign safety_latched        = safe_lat_reg;

   // ============================================================
   // checks
   // ============================================================
   AST_SAFE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      safe_lat_reg && !fault_clear |=> safe_lat_reg)
      else $error("safety latch dropped without clear");
   AST_SAFE_STATE: assert property (@(posedge clk_sys) disable iff (rst)
      safe_lat_reg |=> high_side_output == {3{$past(flt_dat[1])}}
                    && low_side_output == {3{$past(flt_dat[0])}})
      else $error("outputs not in fault state");
   AST_PAIR_OFF: assert property (@(posedge clk_sys) disable iff (rst)
      (flt_act | cl_act) == 3'h0 |=> (high_side_output & low_side_output) == 3'h0)
      else $error("both pins of a pair driven");
   AST_SYNC_OUT: assert property (@(posedge clk_sys) disable iff (rst)
      mtb_end |=> time_base_sync_output && mtb_cnt_reg == 16'h0000)
      else $error("sync output missing at period end");
   AST_SEVT: assert property (@(posedge clk_sys) disable iff (rst)
      tick && mtb_cnt_reg == sevt_cmp |=> special_event_trigger)
      else $error("special event trigger missing");
   AST_EXT_SYNC: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(ext_s) && ext_sync_en |=> mtb_cnt_reg == 16'h0000)
      else $error("external sync did not restart base");
   AST_PRESCALE: assert property (@(posedge clk_sys) disable iff (rst)
      pre_sel == 2'h1 && tick ##1 pre_sel == 2'h1 |-> !tick ##1 tick)
      else $error("divide by two tick spacing wrong");
   AST_FULL_RATE: assert property (@(posedge clk_sys) disable iff (rst)
      pre_sel == 2'h0 && !mtb_wrap |=> mtb_cnt_reg == $past(mtb_cnt_reg) + 16'h0001)
      else $error("no step every clock at divide by one");

   COV_FAULT_CLR: cover property (@(posedge clk_sys) disable iff (rst)
      $fell(safe_lat_reg));
   COV_EXT_SYNC:  cover property (@(posedge clk_sys) disable iff (rst)
      ext_hit);
   COV_CL_ONLY:   cover property (@(posedge clk_sys) disable iff (rst)
      cl_act != 3'h0 && flt_act == 3'h0);

endmodule : high_speed_pwm_core
`default_nettype wire

// *** stage_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// far side: power stage, adc and external sync source
// ============================================================
module stage_model (
   // clock
   input  wire logic       clk_sys,
   // triggers from the core
   input  wire logic [2:0] adc_trigger,
   input  wire logic       special_event_trigger,
   // pins toward the core
   output var logic        external_sync_input,
   output var logic        safety_fault_input
);
   int adc_cnt = 0;  // conversions started by generator 0
   int sev_cnt = 0;  // conversions started by the special event
   // pins start low so the safety latch can be cleared
   initial begin
      external_sync_input = 1'b0;
      safety_fault_input  = 1'b0;
   end
   // each generator 0 or special event trigger starts one conversion
   always @(posedge clk_sys) begin
      adc_cnt <= adc_cnt + int'(adc_trigger[0]);
      sev_cnt <= sev_cnt + int'(special_event_trigger);
   end
   // one sync pulse, two clocks wide, so the synchroniser cannot miss it
   task automatic pulse_sync;
      @(negedge clk_sys) external_sync_input = 1'b1;
      repeat (2) @(negedge clk_sys);
      external_sync_input = 1'b0;
   endtask : pulse_sync
   // safety pin level, changed off the sampling edge
   task automatic set_safety(input logic lvl);
      @(negedge clk_sys) safety_fault_input = lvl;
   endtask : set_safety
endmodule : stage_model
`default_nettype wire

// *** tb_high_speed_pwm_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_high_speed_pwm_core;
   // ============================================================
   // stimulus and observed pins
   // ============================================================
   logic clk_sys = 0, rst = 1, ext_sync_en = 0, flt_mon_en = 0, cl_mon_en = 0, fault_clear = 0;
   logic [1:0] pre_sel = 0, flt_dat = 2'h2, cl_dat = 2'h0;
   logic [15:0] master_period = 16'h0003, sevt_cmp = 16'h0001;
   logic [2:0][15:0] gen_period = {3{16'h0003}}, gen_duty = {3{16'h0002}};
   logic [2:0][15:0] gen_phase = '0, gen_trig_cmp = {3{16'h0001}};
   logic [2:0] center_en = 0, swap_en = 0, chop_en = 0, fault_in = 0, climit_in = 0;
   logic [7:0] chop_div = 8'h03;
   logic [2:0] hi, lo, adc;
   logic sync_o, sev, latched, ext_in, saf_in;
   int miscompares = 0, num_checks = 0, n_sync, n_high, n_other;
   always #25 clk_sys = ~clk_sys;
   high_speed_pwm_core dut (.clk_sys(clk_sys), .rst(rst), .pre_sel(pre_sel),
      .master_period(master_period), .sevt_cmp(sevt_cmp), .ext_sync_en(ext_sync_en),
      .gen_period(gen_period), .gen_duty(gen_duty), .gen_phase(gen_phase),
      .gen_trig_cmp(gen_trig_cmp), .center_en(center_en), .swap_en(swap_en),
      .chop_en(chop_en), .chop_div(chop_div), .flt_mon_en(flt_mon_en), .cl_mon_en(cl_mon_en),
      .flt_dat(flt_dat), .cl_dat(cl_dat), .fault_clear(fault_clear), .fault_in(fault_in),
      .climit_in(climit_in), .safety_fault_input(saf_in), .external_sync_input(ext_in),
      .high_side_output(hi), .low_side_output(lo), .time_base_sync_output(sync_o),
      .adc_trigger(adc), .special_event_trigger(sev), .safety_latched(latched));
   stage_model stage (.clk_sys(clk_sys), .adc_trigger(adc), .special_event_trigger(sev),
      .external_sync_input(ext_in), .safety_fault_input(saf_in));
   // ============================================================
   // shared tasks
   // ============================================================
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d, miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   // settle after a setting change, then count over a whole number of periods
   task automatic meas(input int n);
      repeat (24) @(negedge clk_sys);
      n_sync = 0;
      n_high = 0;
      n_other = 0;
      repeat (n) @(negedge clk_sys) begin
         n_sync += int'(sync_o);
         n_high += int'(hi[0]);
         n_other += int'(hi[1]);
      end
   endtask : meas
   // ============================================================
   // scenarios
   // ============================================================
   task automatic t_latch;
      chk("latch at reset", 16'h0001, 16'(latched));
      chk("safe high pins", 16'h0007, 16'(hi));
      @(negedge clk_sys) fault_clear = 1;
      repeat (4) @(negedge clk_sys);
      chk("latch cleared", 16'h0000, 16'(latched));
      fault_clear = 0;
   endtask : t_latch
   task automatic t_base;
      int a0, s0;
      a0 = stage.adc_cnt;
      s0 = stage.sev_cnt;
      meas(40);
      chk("sync pulses", 16'd10, 16'(n_sync));
      chk("high cycles", 16'd20, 16'(n_high));
      chk("adc triggers", 16'd10, 16'(stage.adc_cnt - a0 - 6));
      chk("special events", 16'd10, 16'(stage.sev_cnt - s0 - 6));
   endtask : t_base
   task automatic t_prescale;
      @(negedge clk_sys) pre_sel = 2'h1;
      meas(40);
      chk("prescaled sync", 16'd5, 16'(n_sync));
      chk("prescaled high", 16'd20, 16'(n_high));
      pre_sel = 2'h0;
   endtask : t_prescale
   task automatic t_swap;
      @(negedge clk_sys) gen_duty[0] = 16'h0001;
      swap_en[0] = 1;
      meas(40);
      chk("swapped high", 16'd30, 16'(n_high));
      chk("other pair high", 16'd20, 16'(n_other));
      swap_en[0] = 0;
      meas(40);
      chk("unswapped high", 16'd10, 16'(n_high));
   endtask : t_swap
   task automatic t_fault;
      @(negedge clk_sys) flt_dat = 2'h1;
      flt_mon_en = 1;
      fault_in[1] = 1;
      repeat (4) @(negedge clk_sys);
      chk("fault pair", 16'h0001, {14'h0000, hi[1], lo[1]});
      fault_in[1] = 0;
      flt_mon_en = 0;
   endtask : t_fault
   // a high safety pin beats the clear; any reset latches again
   task automatic t_safe;
      stage.set_safety(1'b1);
      fault_clear = 1;
      repeat (4) @(negedge clk_sys);
      chk("latch held by pin", 16'h0001, 16'(latched));
      chk("safety low pins", 16'h0007, 16'(lo));
      stage.set_safety(1'b0);
      repeat (4) @(negedge clk_sys);
      chk("latch released", 16'h0000, 16'(latched));
      fault_clear = 0;
      rst = 1;
      repeat (2) @(negedge clk_sys);
      rst = 0;
      repeat (2) @(negedge clk_sys);
      chk("latch after reset", 16'h0001, 16'(latched));
      chk("low pins after reset", 16'h0007, 16'(lo));
   endtask : t_safe
   task automatic t_ext;
      int k;
      @(negedge clk_sys) master_period = 16'h0064;
      ext_sync_en = 1;
      repeat (130) @(negedge clk_sys);
      stage.pulse_sync();
      for (k = 0; k < 6 && sync_o !== 1'b1; k++) @(negedge clk_sys);
      chk("ext restart", 16'h0001, 16'(sync_o));
   endtask : t_ext
   initial begin
      repeat (20) @(negedge clk_sys);
      rst = 0;
      @(negedge clk_sys);
      t_latch();
      t_base();
      t_prescale();
      t_swap();
      t_fault();
      t_safe();
      t_ext();
      results();
   end
endmodule : tb_high_speed_pwm_core
`default_nettype wire
